// >>> rtl/mcgtx_baud_gen.sv
// prescaler, 5-bit divider and divide-by-two forming the baud clock
`timescale 1ns/10ps
module mcgtx_baud_gen (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // engine side
    mcgtx_baud_if.gen bg
);

    logic [4:0] pre;
    logic [4:0] divCnt;
    logic [4:0] preMask;
    logic [4:0] kEff;
    logic [4:0] halfTicks;

    // prohibited select codes behave as the slowest legal one
    assign bg.baseSelEff = (bg.baseSel > mcgtx_pkg::BASE_SEL_MAX) ? mcgtx_pkg::BASE_SEL_MAX : bg.baseSel; // RULE9
    assign preMask       = 5'((6'h01 << bg.baseSelEff) - 6'h01); // RULE9
    assign kEff          = (bg.divisor < mcgtx_pkg::DIV_K_MIN) ? mcgtx_pkg::DIV_K_MIN : bg.divisor; // RULE12
    assign bg.baseTick   = bg.run && ((pre & preMask) == preMask); // RULE9
    assign bg.nearEnd    = (divCnt == 5'(kEff - 5'h01));
    assign bg.halfEnd    = bg.baseTick && bg.nearEnd; // RULE12

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pre <= 5'h00;
        end else if (bg.restart || !bg.run) begin
            pre <= 5'h00;
        end else begin
            pre <= 5'(pre + 5'h01);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            divCnt <= 5'h00;
        end else if (bg.restart) begin
            divCnt <= 5'h00;
        end else if (bg.baseTick) begin
            divCnt <= bg.halfEnd ? 5'h00 : 5'(divCnt + 5'h01);
        end
    end

    // divider output halved: one toggle per k base clocks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bg.phase <= 1'b0;
        end else if (bg.restart) begin
            bg.phase <= 1'b0;
        end else if (bg.halfEnd) begin
            bg.phase <= ~bg.phase; // RULE15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helper: base ticks seen in the current half period
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            halfTicks <= 5'h00;
        end else if (bg.restart || bg.halfEnd) begin
            halfTicks <= 5'h00;
        end else if (bg.baseTick) begin
            halfTicks <= 5'(halfTicks + 5'h01);
        end
    end

    half_len_a: assert property (@(posedge mclk) disable iff (rst)
        (bg.halfEnd && !$past(bg.restart) && $stable(bg.divisor)) |-> (halfTicks <= 5'(kEff - 5'h01))) // RULE15
        else $error("half baud period longer than k base clocks");

endmodule : mcgtx_baud_gen

// >>> rtl/mcgtx_baud_if.sv
// carrier between the transmit engine and its baud generator
`timescale 1ns/10ps
interface mcgtx_baud_if;
    logic [2:0] baseSel;
    logic [4:0] divisor;
    logic       run;
    logic       restart;
    logic       baseTick;
    logic       halfEnd;
    logic       nearEnd;
    logic       phase;
    logic [2:0] baseSelEff;

    modport gen (input baseSel, divisor, run, restart,
                 output baseTick, halfEnd, nearEnd, phase, baseSelEff);
    modport eng (output baseSel, divisor, run, restart,
                 input baseTick, halfEnd, nearEnd, phase, baseSelEff);
endinterface : mcgtx_baud_if

// >>> rtl/mcgtx_pkg.sv
// constants, register map and types of the serial code generator
package mcgtx_pkg;

    // wishbone address width: word index times four
    localparam int          WB_AW          = 18;

    // register indices; byte address is index times four
    localparam logic [15:0] IDX_GEN_CTL    = 16'hff4c;
    localparam logic [15:0] IDX_BASE_SEL   = 16'hff4d;
    localparam logic [15:0] IDX_BAUD_DIV   = 16'hff4e;
    localparam logic [15:0] IDX_TX_BUFFER  = 16'hff50;
    localparam logic [15:0] IDX_TX_BITCNT  = 16'hff51;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hff52;
    localparam logic [15:0] IDX_IRQ_CLEAR  = 16'hff53;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'hff54;

    // generator_control fields
    localparam int          CTL_OP_ENABLE  = 7;
    localparam int          CTL_FIRST_BIT  = 4;
    localparam int          CTL_FORMAT     = 1;
    localparam int          CTL_IDLE_LEVEL = 0;
    localparam logic [7:0]  CTL_MASK       = 8'h93;

    // reset values
    localparam logic [7:0]  RST_GEN_CTL    = 8'h10;
    localparam logic [2:0]  RST_BASE_SEL   = 3'h0;
    localparam logic [4:0]  RST_BAUD_DIV   = 5'h1f;
    localparam logic [2:0]  RST_TX_BITCNT  = 3'h7;
    localparam logic [7:0]  RST_TX_BUFFER  = 8'h00;

    // clock select and divisor limits
    localparam logic [2:0]  BASE_SEL_MAX   = 3'h5;
    localparam logic [4:0]  DIV_K_MIN      = 5'h04;

    // base clocks between last bit and a late-written word
    localparam logic [1:0]  GAP_BASE_CLKS  = 2'h2;

    // interrupt status bit of the load event
    localparam int          IRQ_LOAD_BIT   = 0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_GAP
    } mcgtx_state_t;

endpackage : mcgtx_pkg

// >>> rtl/mcgtx_top.sv
// serial code generator: manchester or bit-sequential transmitter with wishbone registers
// Rules of the document
// RULE1: software loads next word before late window
// RULE2: late window: half baud plus one base
// RULE3: final bit is sent at counter zero
// RULE4: late word starts two base clocks later
// RULE5: software updates bit count before buffer
// RULE6: control 0 holds enable, order, format, idle
// RULE7: control 0 resets 10h, bit writable
// RULE8: software disables before changing mode bits
// RULE9: base clock is peripheral clock over 2^code
// RULE10: control 1 resets zero, upper bits zero
// RULE11: software disables before changing clock select
// RULE12: divisor k from field, small codes four
// RULE13: control 2 resets 1fh, upper bits zero
// RULE14: bit-sequential format drives bits directly
// RULE15: baud clock is divider output halved
// RULE16: start loads counter, shifter, raises interrupt
// RULE17: manchester output is bit xor baud clock
// RULE18: idle or disabled output holds idle level
`timescale 1ns/10ps
module mcgtx_top (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [mcgtx_pkg::WB_AW-1:0] wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output      logic [31:0]                 wb_dat_o,
    output      logic                        wb_ack_o,
    // serial link and interrupt
    output      logic                        serialOutPin,
    output      logic                        txLoadIrq
);

    mcgtx_baud_if bg ();

    logic [7:0]                 genCtl;
    logic [2:0]                 baseSel;
    logic [4:0]                 baudDiv;
    logic [7:0]                 txBuffer;
    logic [2:0]                 txBitCount;
    logic                       irqStatus;
    logic                       irqEnable;
    mcgtx_pkg::mcgtx_state_t    state;
    logic [7:0]                 shiftReg;
    logic [2:0]                 bitCnt;
    logic                       pending;
    logic                       late;
    logic [1:0]                 gapCnt;
    logic [7:0]                 gapCycles;
    logic                       wbReq;
    logic                       wbWrite;
    logic                       lowLane;
    logic [15:0]                adrIdx;
    logic [31:0]                next_rdata;
    logic                       opEnable;
    logic                       lsbFirst;
    logic                       bitSeq;
    logic                       idleLevel;
    logic                       bufWrite;
    logic                       bitEnd;
    logic                       lastBit;
    logic                       lateWin;
    logic                       lastEnd;
    logic                       startNow;
    logic                       outBit;
    logic [7:0]                 loadValue;
    logic                       next_serial;

    ////////////////////////////////////////////////////////////////////////
    // wishbone decode; one wait state, every access acknowledged
    assign wbReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWrite  = wbReq && wb_we_i;
    assign lowLane  = wb_sel_i[0];
    assign adrIdx   = wb_adr_i[mcgtx_pkg::WB_AW-1:2];

    assign opEnable  = genCtl[mcgtx_pkg::CTL_OP_ENABLE]; // RULE6
    assign lsbFirst  = genCtl[mcgtx_pkg::CTL_FIRST_BIT]; // RULE6
    assign bitSeq    = genCtl[mcgtx_pkg::CTL_FORMAT]; // RULE6
    assign idleLevel = genCtl[mcgtx_pkg::CTL_IDLE_LEVEL]; // RULE6

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (adrIdx)
            mcgtx_pkg::IDX_GEN_CTL:    next_rdata = {24'h00_0000, genCtl};
            mcgtx_pkg::IDX_BASE_SEL:   next_rdata = {29'h0000_0000, baseSel}; // RULE10
            mcgtx_pkg::IDX_BAUD_DIV:   next_rdata = {27'h000_0000, baudDiv}; // RULE13
            mcgtx_pkg::IDX_TX_BUFFER:  next_rdata = {24'h00_0000, txBuffer};
            mcgtx_pkg::IDX_TX_BITCNT:  next_rdata = {29'h0000_0000, txBitCount};
            mcgtx_pkg::IDX_IRQ_STATUS: next_rdata = {31'h0000_0000, irqStatus};
            mcgtx_pkg::IDX_IRQ_ENABLE: next_rdata = {31'h0000_0000, irqEnable};
            default:                   next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= (wbReq && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; only the low byte lane carries them
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            genCtl <= mcgtx_pkg::RST_GEN_CTL; // RULE7
        end else if (wbWrite && lowLane && adrIdx == mcgtx_pkg::IDX_GEN_CTL) begin
            genCtl <= wb_dat_i[7:0] & mcgtx_pkg::CTL_MASK; // RULE7
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            baseSel <= mcgtx_pkg::RST_BASE_SEL; // RULE10
            baudDiv <= mcgtx_pkg::RST_BAUD_DIV; // RULE13
        end else if (wbWrite && lowLane) begin
            if (adrIdx == mcgtx_pkg::IDX_BASE_SEL) begin
                baseSel <= wb_dat_i[2:0]; // RULE10
            end
            if (adrIdx == mcgtx_pkg::IDX_BAUD_DIV) begin
                baudDiv <= wb_dat_i[4:0]; // RULE13
            end
        end
    end

    // the count must be written before the buffer; the buffer write starts the word
    assign bufWrite = wbWrite && lowLane && opEnable && adrIdx == mcgtx_pkg::IDX_TX_BUFFER; // RULE5

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            txBuffer   <= mcgtx_pkg::RST_TX_BUFFER;
            txBitCount <= mcgtx_pkg::RST_TX_BITCNT;
        end else begin
            if (bufWrite) begin
                txBuffer <= wb_dat_i[7:0];
            end
            if (wbWrite && lowLane && adrIdx == mcgtx_pkg::IDX_TX_BITCNT) begin
                txBitCount <= wb_dat_i[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt: sticky load flag, set wins over clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqStatus <= 1'b0;
        end else if (startNow) begin
            irqStatus <= 1'b1; // RULE16
        end else if (wbWrite && lowLane && adrIdx == mcgtx_pkg::IDX_IRQ_CLEAR &&
                     wb_dat_i[mcgtx_pkg::IRQ_LOAD_BIT]) begin
            irqStatus <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqEnable <= 1'b0;
        end else if (wbWrite && lowLane && adrIdx == mcgtx_pkg::IDX_IRQ_ENABLE) begin
            irqEnable <= wb_dat_i[mcgtx_pkg::IRQ_LOAD_BIT];
        end
    end

    assign txLoadIrq = irqStatus && irqEnable;

    ////////////////////////////////////////////////////////////////////////
    // baud generator
    assign bg.baseSel = baseSel;
    assign bg.divisor = baudDiv;
    assign bg.run     = opEnable;
    assign bg.restart = startNow;

    mcgtx_baud_gen baudGen (
        .mclk (mclk),
        .rst  (rst),
        .bg   (bg)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmit engine
    assign bitEnd   = bg.halfEnd && bg.phase; // RULE15
    assign lastBit  = (state == mcgtx_pkg::ST_SEND) && (bitCnt == 3'h0); // RULE3
    // late window: second half of the final bit and the base clock before it
    assign lateWin  = lastBit && (bg.phase || bg.nearEnd); // RULE2
    assign lastEnd  = opEnable && lastBit && bitEnd; // RULE3
    assign startNow = opEnable && pending && (
                      (state == mcgtx_pkg::ST_IDLE) ||
                      (lastEnd && !late && !bufWrite) || // RULE4
                      (state == mcgtx_pkg::ST_GAP && bg.baseTick &&
                       gapCnt == 2'(mcgtx_pkg::GAP_BASE_CLKS - 2'h1))); // RULE4

    // words are held low-aligned; msb-first data is moved to the top for a left shift
    assign loadValue = lsbFirst ? txBuffer : 8'(txBuffer << (3'h7 - txBitCount));
    assign outBit    = lsbFirst ? shiftReg[0] : shiftReg[7];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= mcgtx_pkg::ST_IDLE;
        end else if (!opEnable) begin
            state <= mcgtx_pkg::ST_IDLE; // RULE18
        end else if (startNow) begin
            state <= mcgtx_pkg::ST_SEND;
        end else if (lastEnd) begin
            state <= (pending || bufWrite) ? mcgtx_pkg::ST_GAP : mcgtx_pkg::ST_IDLE; // RULE4
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pending <= 1'b0;
            late    <= 1'b0;
        end else if (!opEnable) begin
            pending <= 1'b0;
            late    <= 1'b0;
        end else begin
            pending <= bufWrite || (pending && !startNow);
            late    <= (bufWrite && lateWin) || (late && !startNow); // RULE2
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gapCnt <= 2'h0;
        end else if (state != mcgtx_pkg::ST_GAP) begin
            gapCnt <= 2'h0;
        end else if (bg.baseTick) begin
            gapCnt <= 2'(gapCnt + 2'h1); // RULE4
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shiftReg <= 8'h00;
            bitCnt   <= 3'h0;
        end else if (startNow) begin
            shiftReg <= loadValue; // RULE16
            bitCnt   <= txBitCount; // RULE16
        end else if (state == mcgtx_pkg::ST_SEND && bitEnd && bitCnt != 3'h0) begin
            shiftReg <= lsbFirst ? {1'b0, shiftReg[7:1]} : {shiftReg[6:0], 1'b0}; // RULE17
            bitCnt   <= 3'(bitCnt - 3'h1); // RULE3
        end
    end

    always_comb begin
        next_serial = idleLevel; // RULE18
        if (state == mcgtx_pkg::ST_SEND && opEnable) begin
            next_serial = bitSeq ? outBit : (outBit ^ bg.phase); // RULE14 RULE17
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            serialOutPin <= 1'b0;
        end else begin
            serialOutPin <= next_serial;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helper: cycles spent in the gap
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gapCycles <= 8'h00;
        end else if (state == mcgtx_pkg::ST_GAP) begin
            gapCycles <= 8'(gapCycles + 8'h01);
        end else begin
            gapCycles <= 8'h01;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence lateFinish;
        lastEnd && (late || bufWrite) && opEnable;
    endsequence

    sequence onTime;
        lastEnd && pending && !late && !bufWrite;
    endsequence

    idle_level_a: assert property ((state == mcgtx_pkg::ST_IDLE) |=> serialOutPin == $past(idleLevel)) // RULE18
        else $error("idle output differs from idle level");

    load_irq_a: assert property (startNow |=> irqStatus && bitCnt == $past(txBitCount)) // RULE16
        else $error("start did not load counter or raise interrupt");

    shift_load_a: assert property (startNow |=> shiftReg == $past(loadValue) && state == mcgtx_pkg::ST_SEND) // RULE16
        else $error("start did not load shift register");

    manch_half_a: assert property ((state == mcgtx_pkg::ST_SEND && !bitSeq && opEnable && bg.halfEnd && !bg.phase &&
        !startNow) |=> ##1 (serialOutPin != $past(serialOutPin, 2))) // RULE17
        else $error("manchester output did not invert at mid bit");

    seq_out_a: assert property ((state == mcgtx_pkg::ST_SEND && bitSeq && opEnable) |=> serialOutPin == $past(outBit)) // RULE14
        else $error("bit-sequential output differs from data bit");

    seamless_a: assert property (onTime |-> startNow) // RULE4
        else $error("on-time word did not start seamlessly");

    gap_enter_a: assert property (lateFinish |=> state == mcgtx_pkg::ST_GAP && !startNow) // RULE4
        else $error("late word did not wait in gap");

    gap_len_a: assert property ((state == mcgtx_pkg::ST_GAP && startNow) |->
        gapCycles == 8'(8'h02 << bg.baseSelEff)) // RULE4
        else $error("gap not two base clocks long");

    late_win_a: assert property ((bufWrite && lateWin) |=> late) // RULE2
        else $error("write in late window not marked late");

    last_bit_a: assert property ((lastEnd && !startNow) |=> state != mcgtx_pkg::ST_SEND) // RULE3
        else $error("word kept sending after counter zero");

    ctl1_read_a: assert property ((wbReq && !wb_we_i && adrIdx == mcgtx_pkg::IDX_BASE_SEL) |=>
        wb_ack_o && wb_dat_o[31:3] == 29'h0000_0000) // RULE10
        else $error("base clock select upper bits not zero");

endmodule : mcgtx_top

// >>> verification/mcgtx_rx_model.sv
// receiver model that decodes the serial output stream
`timescale 1ns/10ps
module mcgtx_rx_model (
    // clock and line
    input  wire logic        mclk,
    input  wire logic        pin,
    // framing set by the bench
    input  wire logic        go,
    input  wire logic        manch,
    input  wire logic [15:0] halfLen,
    input  wire logic [4:0]  nBits,
    input  wire logic [4:0]  splitAt,
    input  wire logic [7:0]  gap,
    // decoded result
    output      logic [15:0] rxWord,
    output      logic        codeErr,
    output      logic        rxDone
);
    logic s0;
    // one process owns the outputs; waiting a clock first skips the time-zero settling of go
    // samples sit mid half-bit, so a one-cycle start skew is tolerated
    initial begin
        rxWord = 16'h0000;
        codeErr = 1'b0;
        rxDone = 1'b0;
        @(posedge mclk);
        forever begin
            @(go);
            rxWord = 16'h0000;
            codeErr = 1'b0;
            for (int h = 0; h < 2 * nBits; h++) begin
                repeat ((h == 0) ? 2 + halfLen / 2 : halfLen) @(posedge mclk);
                // a late word pauses the stream before its first bit
                if (h == 2 * splitAt && h != 0) repeat (gap) @(posedge mclk);
                #1;
                if (h % 2 == 0) begin
                    s0 = pin;
                end else begin
                    rxWord = {rxWord[14:0], s0};
                    if (manch ? (pin === s0) : (pin !== s0)) codeErr = 1'b1;
                end
            end
            rxDone = ~rxDone;
        end
    end
endmodule : mcgtx_rx_model

// >>> verification/testbench.sv
// self-checking bench of the serial code generator
`timescale 1ns/10ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin errTotal++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    logic        mclk, rst, cyc, stb, wen, go, manch;
    logic [17:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat, dout, r;
    logic        ack, pinOut, irq, codeErr, rxDone;
    logic [15:0] halfLen, rxWord;
    logic [4:0]  nBits, splitAt, kc;
    logic [7:0]  gap, rd, ctl, d1, d2;
    int          errTotal, checkCount, seed, kEff, hl, n1, n2;

    mcgtx_top dut_u (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .serialOutPin(pinOut), .txLoadIrq(irq));
    mcgtx_rx_model rx_u (.mclk(mclk), .pin(pinOut), .go(go), .manch(manch), .halfLen(halfLen),
        .nBits(nBits), .splitAt(splitAt), .gap(gap), .rxWord(rxWord), .codeErr(codeErr), .rxDone(rxDone));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrapUp();
        $display("checks %0d errors %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrapUp
    // request held until ack is sampled at a rising edge
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        int n;
        @(posedge mclk);
        {cyc, stb, wen} <= {2'b11, w};
        adr <= {idx, 2'b00};
        dat <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        rd = dout[7:0];
        {cyc, stb, wen} <= 3'h0;
        if (n >= 16) begin
            errTotal++;
            $display("[ERR] %0t bus access never acknowledged", $time);
            wrapUp();
        end
    endtask : wb
    task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        `CHK(rd, e)
    endtask : rchk
    task automatic settle();
        @(posedge mclk);
        #1;
    endtask : settle
    task automatic waitRx();
        logic p;
        int   n;
        p = rxDone;
        n = 0;
        while (rxDone === p && n < 40000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 40000) begin
            errTotal++;
            $display("[ERR] %0t receiver never finished a frame", $time);
            wrapUp();
        end
    endtask : waitRx
    // bits in line order, first sent bit highest
    function automatic logic [15:0] expBits(input logic [7:0] d, input int n, input logic lsb);
        logic [15:0] e;
        e = 16'h0000;
        for (int i = 0; i <= n; i++) e[n - i] = lsb ? d[i] : d[n - i];
        return e;
    endfunction : expBits
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 6;
        errTotal = 0;
        checkCount = 0;
        rst = 1'b1;
        {cyc, stb, wen} = 3'h0;
        adr = 18'h00000;
        sel = 4'hf;
        dat = 32'h00000000;
        go = 1'b0;
        manch = 1'b1;
        {halfLen, nBits, splitAt, gap} = '0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rchk(mcgtx_pkg::IDX_GEN_CTL, 8'h10);
        rchk(mcgtx_pkg::IDX_BASE_SEL, 8'h00);
        rchk(mcgtx_pkg::IDX_BAUD_DIV, 8'h1f);
        ctl = 8'h12;
        wb(1'b1, mcgtx_pkg::IDX_GEN_CTL, 8'h7e);
        rchk(mcgtx_pkg::IDX_GEN_CTL, ctl);
        wb(1'b1, mcgtx_pkg::IDX_BASE_SEL, 8'hfd);
        rchk(mcgtx_pkg::IDX_BASE_SEL, 8'h05);
        wb(1'b1, mcgtx_pkg::IDX_BAUD_DIV, 8'hea);
        rchk(mcgtx_pkg::IDX_BAUD_DIV, 8'h0a);
        // a write without the low byte lane is acknowledged and dropped
        sel <= 4'he;
        wb(1'b1, mcgtx_pkg::IDX_BAUD_DIV, 8'h03);
        sel <= 4'hf;
        rchk(mcgtx_pkg::IDX_BAUD_DIV, 8'h0a);
        rchk(16'hff60, 8'h00);
        wb(1'b1, mcgtx_pkg::IDX_IRQ_ENABLE, 8'h01);
        // every legal clock select code, odd passes write the second word late
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            d1 = r[7:0];
            d2 = r[15:8];
            n2 = r[18:16];
            n1 = 1 + r[21:19] % 7;
            kc = (i == 0) ? 5'h00 : ((i < 3) ? r[31:27] : {2'b00, r[29:27]});
            kEff = (kc < 4) ? 4 : kc;
            hl = kEff << i;
            wb(1'b1, mcgtx_pkg::IDX_GEN_CTL, ctl & 8'h7f);
            // format and bit order cycle with the pass so each mode is sent; idle level stays random
            ctl = 8'h80 | {3'h0, i[0] ^ i[2], 2'h0, i[1], r[26]};
            wb(1'b1, mcgtx_pkg::IDX_BASE_SEL, 8'(i));
            wb(1'b1, mcgtx_pkg::IDX_BAUD_DIV, {3'h0, kc});
            wb(1'b1, mcgtx_pkg::IDX_GEN_CTL, ctl);
            halfLen = 16'(hl);
            manch = ~ctl[1];
            nBits = 5'(n1 + n2 + 2);
            splitAt = 5'(n1 + 1);
            gap = (i % 2 == 1) ? 8'(2 << i) : 8'h00;
            wb(1'b1, mcgtx_pkg::IDX_TX_BITCNT, 8'(n1));
            wb(1'b1, mcgtx_pkg::IDX_TX_BUFFER, d1);
            go = ~go;
            wb(1'b1, mcgtx_pkg::IDX_TX_BITCNT, 8'(n2));
            if (i % 2 == 1) repeat ((2 * n1 + 1) * hl + hl / 2 - 4) @(posedge mclk);
            wb(1'b1, mcgtx_pkg::IDX_TX_BUFFER, d2);
            waitRx();
            `CHK(rxWord, 16'((expBits(d1, n1, ctl[4]) << (n2 + 1)) | expBits(d2, n2, ctl[4])))
            `CHK(codeErr, 1'b0)
            repeat (hl / 2 + 3) @(posedge mclk);
            #1;
            `CHK(pinOut, ctl[0])
            `CHK(irq, 1'b1)
            wb(1'b1, mcgtx_pkg::IDX_IRQ_CLEAR, 8'h01);
            settle();
            `CHK(irq, 1'b0)
        end
        // mask the interrupt, then abort a word by clearing the enable
        wb(1'b1, mcgtx_pkg::IDX_IRQ_ENABLE, 8'h00);
        wb(1'b1, mcgtx_pkg::IDX_TX_BITCNT, 8'h07);
        wb(1'b1, mcgtx_pkg::IDX_TX_BUFFER, ~{8{ctl[0]}});
        repeat (20) @(posedge mclk);
        wb(1'b1, mcgtx_pkg::IDX_GEN_CTL, ctl & 8'h7f);
        settle();
        for (int j = 0; j < 4; j++) begin
            settle();
            `CHK(pinOut, ctl[0])
        end
        `CHK(irq, 1'b0)
        rchk(mcgtx_pkg::IDX_IRQ_STATUS, 8'h01);
        wrapUp();
    end
endmodule : testbench
